// file: shared/lps_pkg.sv
// constants, types and the register map of the lcd power save sequencer
// assumes a 32-bit apb master on pclk and a panel clock on its own domain
package lps_pkg;
    // register byte offsets
    localparam logic [7:0] LPS_ADDR_POWER = 8'h00;
    localparam logic [7:0] LPS_ADDR_PINS = 8'h04;
    localparam logic [7:0] LPS_ADDR_STATUS = 8'h08;
    // power_mode_control fields
    localparam int LPS_MODE_LSB = 0;
    localparam logic [1:0] LPS_MODE_RESET = 2'h0;
    localparam logic [1:0] LPS_MODE_SW_SAVE = 2'h0;
    localparam logic [1:0] LPS_MODE_NORMAL = 2'h3;
    // pin configuration fields
    localparam int LPS_GPIO_EN_BIT = 0;
    localparam int LPS_HW_CFG_BIT = 1;
    localparam int LPS_GPIO_VAL_LSB = 4;
    localparam logic [5:0] LPS_PINS_RESET = 6'h00;
    // status fields
    localparam int LPS_ST_NORMAL_BIT = 0;
    localparam int LPS_ST_HW_BIT = 1;
    localparam int LPS_ST_SW_BIT = 2;
    localparam int LPS_ST_POWER_BIT = 3;
    localparam int LPS_ST_ACTIVE_BIT = 4;
    localparam int LPS_ST_CLKOK_BIT = 5;
    // timing in frames
    localparam logic [6:0] LPS_SEQ_DELAY_FRAMES = 7'h7F;
    localparam logic [7:0] LPS_CLK_STOP_FRAMES = 8'h80;

    typedef enum logic [1:0] {
        LPS_SEQ_OFF = 2'b00,
        LPS_SEQ_UP_WAIT = 2'b01,
        LPS_SEQ_ON = 2'b10,
        LPS_SEQ_DOWN_WAIT = 2'b11
    } lps_seq_t;

    typedef struct packed {
        logic power;
        logic [11:0] pixel;
        logic shift;
        logic line;
        logic frame;
        logic valid;
    } lps_panel_t;
endpackage

// file: logic/lps_sequencer.sv
// power save mode decode, apb register file and panel power sequencer
// assumes input_clock is unrelated to pclk; presetn resets both domains
//
// Notes on behaviour
// - the two mode bits select software save at 00 and normal at 11, mixed codes are reserved, and a configured asserted hardware save pin overrides them.
// - software save stops refresh and powers the panel down while register and memory access stay open.
// - hardware save closes host access to registers and memory on top of stopping refresh and panel power.
// - in either save mode the panel power goes low, and after the down wait the panel timing and non-gpio pixel outputs go low; the frame counters keep running.
// - upper four pixel pins set as general purpose outputs keep their level through power save.
// - after reset panel power is off and all panel outputs except pixel pins set as general purpose outputs stay low until normal operation is chosen.
// - software programs everything else and writes 11 to the mode bits last, which starts power up.
// - each phase of the power up and power down sequence is separated by 127 frames.
// - entering software save runs power down and leaving it for normal runs power up, as after reset.
`timescale 1ns/1ps
module lps_sequencer
    import lps_pkg::*;
#(
    parameter int LINE_CLOCKS = 16,
    parameter int FRAME_LINES = 8
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // hardware power save pin, asynchronous
    input wire logic hw_save_pin,
    // gating towards the memory and refresh logic
    output logic memory_access_enable,
    output logic refresh_read_enable,
    // panel side
    input wire logic input_clock,
    output lps_panel_t panel
);
    if (LINE_CLOCKS < 4 || FRAME_LINES < 2) begin : g_size_check
        $error("lps_sequencer: line or frame length too short");
    end

    localparam int LCW = $clog2(LINE_CLOCKS);
    localparam int FLW = $clog2(FRAME_LINES);
    localparam logic [LCW-1:0] LINE_LAST = LCW'(LINE_CLOCKS - 1);
    localparam logic [FLW-1:0] FRAME_LAST = FLW'(FRAME_LINES - 1);

    // ---------------- pclk domain ----------------
    logic [1:0] mode;
    logic [5:0] pins;
    logic hw_pin_meta;
    logic hw_pin_sync;
    logic [1:0] power_meta;
    logic [1:0] power_sync;
    logic clkok_meta;
    logic clkok_sync;
    // panel domain levels that the synchronisers below pick up
    logic seq_active;
    logic panel_power_on;
    logic clock_stop_ok;

    wire hw_save_active = pins[LPS_HW_CFG_BIT] & hw_pin_sync;
    wire normal_sel = !hw_save_active && (mode == LPS_MODE_NORMAL);
    wire sw_save_sel = !hw_save_active && (mode == LPS_MODE_SW_SAVE);
    // reserved codes keep the panel down: powering an unconfigured panel is the hazard
    wire want_on = normal_sel;

    wire setup = psel && !penable;
    wire access = psel && penable;
    wire hit_power = (paddr == LPS_ADDR_POWER);
    wire hit_pins = (paddr == LPS_ADDR_PINS);
    wire hit_status = (paddr == LPS_ADDR_STATUS);
    wire mapped = hit_power || hit_pins || hit_status;
    wire bus_open = !hw_save_active;
    wire wr_ok = access && pwrite && bus_open;
    wire wr_power = wr_ok && hit_power;
    wire wr_pins = wr_ok && hit_pins;

    wire [31:0] status_word = {26'h0, clkok_sync, power_sync[1], power_sync[0],
        sw_save_sel, hw_save_active, normal_sel};
    wire [31:0] read_mux = !bus_open ? 32'h0 :
        hit_power ? {30'h0, mode} :
        hit_pins ? {24'h0, pins[5:2], 2'h0, pins[1:0]} :
        hit_status ? status_word : 32'h0;

    assign pready = 1'b1;
    assign pslverr = access && (!mapped || !bus_open);
    assign memory_access_enable = bus_open;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= LPS_MODE_RESET;
            pins <= LPS_PINS_RESET;
        end else begin
            if (wr_power) begin
                mode <= pwdata[LPS_MODE_LSB +: 2];
            end
            if (wr_pins) begin
                pins <= {pwdata[LPS_GPIO_VAL_LSB +: 4], pwdata[LPS_HW_CFG_BIT],
                    pwdata[LPS_GPIO_EN_BIT]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= read_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_pin_meta <= 1'b0;
            hw_pin_sync <= 1'b0;
            power_meta <= 2'h0;
            power_sync <= 2'h0;
            clkok_meta <= 1'b0;
            clkok_sync <= 1'b0;
        end else begin
            hw_pin_meta <= hw_save_pin;
            hw_pin_sync <= hw_pin_meta;
            power_meta <= {seq_active, panel_power_on};
            power_sync <= power_meta;
            clkok_meta <= clock_stop_ok;
            clkok_sync <= clkok_meta;
        end
    end

    // ---------------- input_clock domain ----------------
    logic rst_meta_n;
    logic prst_n;
    logic [5:0] cfg_meta;
    logic [5:0] cfg_sync;
    logic want_meta;
    logic want_sync;
    lps_seq_t state;
    lps_seq_t next_state;
    logic [LCW-1:0] line_cnt;
    logic [FLW-1:0] line_idx;
    logic [6:0] seq_frames;
    logic [7:0] save_frames;
    logic [7:0] pix_cnt;

    always_ff @(posedge input_clock or negedge presetn) begin
        if (!presetn) begin
            rst_meta_n <= 1'b0;
            prst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            prst_n <= rst_meta_n;
        end
    end

    // quasi-static settings: software changes them far apart from panel use
    always_ff @(posedge input_clock or negedge prst_n) begin
        if (!prst_n) begin
            cfg_meta <= LPS_PINS_RESET;
            cfg_sync <= LPS_PINS_RESET;
            want_meta <= 1'b0;
            want_sync <= 1'b0;
        end else begin
            cfg_meta <= pins;
            cfg_sync <= cfg_meta;
            want_meta <= want_on;
            want_sync <= want_meta;
        end
    end

    wire gpio_en = cfg_sync[LPS_GPIO_EN_BIT];
    wire [3:0] gpio_val = cfg_sync[5:2];
    wire line_end = (line_cnt == LINE_LAST);
    wire frame_tick = line_end && (line_idx == FRAME_LAST);
    wire delay_done = frame_tick && (seq_frames == LPS_SEQ_DELAY_FRAMES - 7'h01);

    always_comb begin
        next_state = state;
        case (state)
            LPS_SEQ_OFF: begin
                if (want_sync) begin
                    next_state = LPS_SEQ_UP_WAIT;
                end
            end
            LPS_SEQ_UP_WAIT: begin
                if (!want_sync) begin
                    next_state = LPS_SEQ_OFF;
                end else if (delay_done) begin
                    next_state = LPS_SEQ_ON;
                end
            end
            LPS_SEQ_ON: begin
                if (!want_sync) begin
                    next_state = LPS_SEQ_DOWN_WAIT;
                end
            end
            LPS_SEQ_DOWN_WAIT: begin
                if (want_sync) begin
                    next_state = LPS_SEQ_UP_WAIT;
                end else if (delay_done) begin
                    next_state = LPS_SEQ_OFF;
                end
            end
            default: begin
                next_state = LPS_SEQ_OFF;
            end
        endcase
    end

    assign seq_active = (state != LPS_SEQ_OFF);
    assign panel_power_on = (state == LPS_SEQ_ON);
    assign clock_stop_ok = (save_frames == LPS_CLK_STOP_FRAMES);
    assign refresh_read_enable = power_sync[1];

    always_ff @(posedge input_clock or negedge prst_n) begin
        if (!prst_n) begin
            state <= LPS_SEQ_OFF;
            seq_frames <= 7'h00;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                seq_frames <= 7'h00;
            end else if (frame_tick) begin
                seq_frames <= seq_frames + 7'h01;
            end
        end
    end

    // frame timing always counts so that delays and the clock stop window advance
    always_ff @(posedge input_clock or negedge prst_n) begin
        if (!prst_n) begin
            line_cnt <= '0;
            line_idx <= '0;
        end else begin
            line_cnt <= line_end ? '0 : line_cnt + LCW'(1);
            if (line_end) begin
                line_idx <= (line_idx == FRAME_LAST) ? '0 : line_idx + FLW'(1);
            end
        end
    end

    always_ff @(posedge input_clock or negedge prst_n) begin
        if (!prst_n) begin
            save_frames <= 8'h00;
        end else if (want_sync) begin
            save_frames <= 8'h00;
        end else if (frame_tick && !clock_stop_ok) begin
            save_frames <= save_frames + 8'h01;
        end
    end

    always_ff @(posedge input_clock or negedge prst_n) begin
        if (!prst_n) begin
            pix_cnt <= 8'h00;
        end else if (seq_active) begin
            pix_cnt <= pix_cnt + 8'h01;
        end else begin
            pix_cnt <= 8'h00;
        end
    end

    wire [3:0] upper_pix = gpio_en ? gpio_val : (seq_active ? pix_cnt[7:4] : 4'h0);
    lps_panel_t next_panel;
    assign next_panel.power = panel_power_on;
    assign next_panel.pixel = {upper_pix, seq_active ? pix_cnt : 8'h00};
    assign next_panel.shift = seq_active && line_cnt[0];
    assign next_panel.line = seq_active && line_end;
    assign next_panel.frame = seq_active && (line_idx == '0) && line_end;
    assign next_panel.valid = seq_active && !line_end;

    always_ff @(posedge input_clock or negedge prst_n) begin
        if (!prst_n) begin
            panel <= '0;
        end else begin
            panel <= next_panel;
        end
    end

    // ---------------- checks ----------------
    a_power_after_outputs: assert property (@(posedge input_clock)
        disable iff (!prst_n)
        $rose(panel.power) |-> $past(state, 2) == LPS_SEQ_UP_WAIT)
        else $error("panel power rose without the up wait phase");
    a_up_delay_count: assert property (@(posedge input_clock)
        disable iff (!prst_n)
        (state == LPS_SEQ_ON && $past(state) == LPS_SEQ_UP_WAIT) |->
        $past(seq_frames) == LPS_SEQ_DELAY_FRAMES - 7'h01)
        else $error("power up delay is not 127 frames");
    a_down_delay_count: assert property (@(posedge input_clock)
        disable iff (!prst_n)
        (state == LPS_SEQ_OFF && $past(state) == LPS_SEQ_DOWN_WAIT) |->
        $past(seq_frames) == LPS_SEQ_DELAY_FRAMES - 7'h01)
        else $error("power down delay is not 127 frames");
    a_down_power_first: assert property (@(posedge input_clock)
        disable iff (!prst_n)
        (state == LPS_SEQ_ON && !want_sync) |=> state == LPS_SEQ_DOWN_WAIT ##1 !panel.power)
        else $error("power down did not drop panel power first");
    a_down_power_low: assert property (@(posedge input_clock)
        disable iff (!prst_n)
        state == LPS_SEQ_DOWN_WAIT |=> !panel.power)
        else $error("panel power high during the down wait phase");
    a_off_outputs_low: assert property (@(posedge input_clock)
        disable iff (!prst_n)
        $past(state) == LPS_SEQ_OFF |-> !panel.power && !panel.shift && !panel.line &&
        !panel.frame && !panel.valid && panel.pixel[7:0] == 8'h00)
        else $error("panel outputs not low while sequencer off");
    a_gpio_pins_hold: assert property (@(posedge input_clock)
        disable iff (!prst_n)
        (gpio_en && $stable(gpio_val)) |=> panel.pixel[11:8] == $past(gpio_val))
        else $error("gpio pixel pins changed in power save");
    a_clock_stop_window: assert property (@(posedge input_clock)
        disable iff (!prst_n)
        $rose(clock_stop_ok) |-> $past(frame_tick) && !$past(want_sync))
        else $error("clock stop flag raised early");
    a_hw_write_blocked: assert property (@(posedge pclk)
        disable iff (!presetn)
        (hw_save_active && access && pwrite) |=> $stable(mode) && $stable(pins))
        else $error("register changed in hardware save");
    a_hw_error_answer: assert property (@(posedge pclk)
        disable iff (!presetn)
        (hw_save_active && access) |-> pslverr && !memory_access_enable)
        else $error("host access not refused in hardware save");
    a_sw_save_access: assert property (@(posedge pclk)
        disable iff (!presetn)
        (sw_save_sel && access && mapped) |-> !pslverr && memory_access_enable)
        else $error("host access refused in software save");
    a_mode_decode: assert property (@(posedge pclk)
        disable iff (!presetn)
        (!hw_save_active && mode == 2'h3) |-> want_on && !sw_save_sel)
        else $error("normal code not decoded");
    a_power_write_start: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_power && pwdata[1:0] == 2'h3 && !pins[LPS_HW_CFG_BIT]) |=> want_on)
        else $error("writing 11 did not request power up");
endmodule

// file: bench/lps_panel_model.sv
// panel side model: makes the link clock and watches the panel pins
// assumes the bench holds hold_clock only when the input clock may stop
`timescale 1ns/1ps
module lps_panel_model
    import lps_pkg::*;
(
    // clock source
    input wire logic hold_clock,
    output logic input_clock,
    // panel pins
    input wire lps_panel_t panel,
    output logic early_power,
    output logic activity_seen
);
    logic prev_power;
    int idle_n;

    // parks only on a low level, so a stop never leaves a short pulse
    initial begin
        input_clock = 1'b0;
        #37;
        forever begin
            #80;
            if (!hold_clock || input_clock) begin
                input_clock = ~input_clock;
            end
        end
    end

    initial begin
        early_power = 1'b0;
        activity_seen = 1'b0;
        prev_power = 1'b0;
        idle_n = 0;
    end

    // a panel powered before its timing runs would be damaged
    always @(posedge input_clock) begin
        if (panel.power && !prev_power && !activity_seen) begin
            early_power <= 1'b1;
        end
        prev_power <= panel.power;
        if (panel.shift || panel.line || panel.frame || panel.valid) begin
            activity_seen <= 1'b1;
            idle_n <= 0;
        end else if (idle_n >= 16) begin
            activity_seen <= 1'b0;
        end else begin
            idle_n <= idle_n + 1;
        end
    end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the power save sequencer
// assumes the panel model supplies input_clock; apb driven on pclk
`timescale 1ns/1ps
module tb_top
    import lps_pkg::*;
;
    localparam int FR = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic hw_save_pin, memory_access_enable, refresh_read_enable;
    logic input_clock, hold_clock, early_power, activity_seen, er;
    lps_panel_t panel;
    int fail_count, n_checks, cyc;

    lps_sequencer #(.LINE_CLOCKS(4), .FRAME_LINES(2)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hw_save_pin(hw_save_pin),
        .memory_access_enable(memory_access_enable),
        .refresh_read_enable(refresh_read_enable),
        .input_clock(input_clock), .panel(panel));

    lps_panel_model far_end (
        .hold_clock(hold_clock), .input_clock(input_clock), .panel(panel),
        .early_power(early_power), .activity_seen(activity_seen));

    // bus clock never stops, so every host stop and restart rule holds throughout
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // holds the request until pready is seen high with penable
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) fail_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // ends mid link cycle and on a bus edge: panel outputs settled, apb may start
    task automatic wic(input int n);
        repeat (n) @(posedge input_clock);
        @(negedge input_clock);
        @(posedge pclk);
    endtask

    task automatic wait_power(input logic lvl, input int lim);
        int n;
        n = 0;
        while (panel.power !== lvl && n < lim) begin
            n++;
            @(posedge input_clock);
        end
        chk("panel power", {31'h0, panel.power}, {31'h0, lvl});
        @(posedge pclk);
    endtask

    // gpio nibble is excluded: it keeps its programmed level
    task automatic chk_low();
        chk("panel outputs", {15'h0, panel.power, 4'h0, panel.pixel[7:0], panel.shift,
            panel.line, panel.frame, panel.valid}, 32'h0);
    endtask

    initial begin
        {psel, penable, pwrite, hw_save_pin, hold_clock, presetn} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        fail_count = 0;
        n_checks = 0;
        cyc = 0;
        repeat (16) @(posedge pclk);
        wic(3);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_low();
        chk("refresh", {31'h0, refresh_read_enable}, 32'h0);
        apb(1'b0, LPS_ADDR_POWER, 32'h0);
        chk("mode reset", rd, 32'h0);
        apb(1'b0, LPS_ADDR_STATUS, 32'h0);
        chk("status reset", rd, 32'h4);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        apb(1'b1, LPS_ADDR_PINS, 32'hA3);
        apb(1'b0, LPS_ADDR_PINS, 32'h0);
        chk("pins", rd, 32'hA3);
        wic(4 * FR);
        chk_low();
        apb(1'b1, LPS_ADDR_POWER, 32'h3);
        wic(120 * FR);
        chk("power early", {31'h0, panel.power}, 32'h0);
        chk("timing first", {31'h0, activity_seen}, 32'h1);
        wait_power(1'b1, 12 * FR);
        wic(4);
        apb(1'b0, LPS_ADDR_STATUS, 32'h0);
        chk("status normal", rd, 32'h19);
        chk("refresh on", {31'h0, refresh_read_enable}, 32'h1);
        apb(1'b1, LPS_ADDR_POWER, 32'h0);
        wic(4);
        chk("power off first", {31'h0, panel.power}, 32'h0);
        chk("timing kept", {31'h0, activity_seen}, 32'h1);
        apb(1'b0, LPS_ADDR_PINS, 32'h0);
        chk("sw save access", {er, rd[30:0]}, 32'hA3);
        chk("mem enable", {31'h0, memory_access_enable}, 32'h1);
        wic(116 * FR);
        apb(1'b0, LPS_ADDR_STATUS, 32'h0);
        chk("status down wait", rd, 32'h14);
        wic(13 * FR);
        chk_low();
        chk("gpio kept", {28'h0, panel.pixel[11:8]}, 32'hA);
        chk("refresh off", {31'h0, refresh_read_enable}, 32'h0);
        apb(1'b0, LPS_ADDR_STATUS, 32'h0);
        chk("status clock ok", rd, 32'h24);
        hold_clock <= 1'b1;
        repeat (300) @(posedge pclk);
        chk_low();
        hold_clock <= 1'b0;
        for (int m = 1; m < 3; m++) begin
            apb(1'b1, LPS_ADDR_POWER, m);
            wic(4 * FR);
            apb(1'b0, LPS_ADDR_STATUS, 32'h0);
            chk("reserved mode", rd & 32'h7, 32'h0);
            chk_low();
        end
        apb(1'b1, LPS_ADDR_POWER, 32'h3);
        wait_power(1'b1, 135 * FR);
        hw_save_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("hw mem enable", {31'h0, memory_access_enable}, 32'h0);
        apb(1'b0, LPS_ADDR_STATUS, 32'h0);
        chk("hw read", {er, rd[30:0]}, 32'h80000000);
        apb(1'b1, LPS_ADDR_POWER, 32'h0);
        chk("hw write", {31'h0, er}, 32'h1);
        wic(4);
        chk("hw power", {31'h0, panel.power}, 32'h0);
        chk("hw gpio", {28'h0, panel.pixel[11:8]}, 32'hA);
        hw_save_pin <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, LPS_ADDR_POWER, 32'h0);
        chk("mode kept", {er, rd[30:0]}, 32'h3);
        chk("early power", {31'h0, early_power}, 32'h0);
        finish_test();
    end
endmodule
